// >>> common/tick_supervisor_consts.svh
/*
  Holds the register offsets, field positions, reset values and key constant of the
  tick timer and supervisor unit.
  Assumes that it is included by its bare name and holds definitions only.
*/
`ifndef TICK_SUPERVISOR_CONSTS_SVH
`define TICK_SUPERVISOR_CONSTS_SVH

// --------------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// --------------------------------------------------------------------------
`define TS_ADDR_CONFIG 3'h0
`define TS_ADDR_PRESCALER 3'h1
`define TS_ADDR_PRESET 3'h2
`define TS_ADDR_CSR 3'h3
`define TS_ADDR_COUNT 3'h4
`define TS_ADDR_KEY 3'h5

// --------------------------------------------------------------------------
// Field positions
// --------------------------------------------------------------------------
`define TS_CFG_LOCK_CFG 0
`define TS_CFG_LOCK_PRE 1
`define TS_CFG_LOCK_TICK 2
`define TS_CFG_LOCK_CNT 3
`define TS_CFG_CLK_SEL 4
`define TS_CFG_KEY_EN 5
`define TS_CSR_RESTART 0
`define TS_CSR_TC 1

// --------------------------------------------------------------------------
// Masks, reset values and constants
// --------------------------------------------------------------------------
`define TS_CFG_LOCK_MASK 8'h0f
`define TS_CFG_MASK 8'h3f
`define TS_CFG_RESET 8'h00
`define TS_DIV_RESET 3'h0
`define TS_DIV_MAX 3'h5
`define TS_PRESET_RESET 16'hffff
`define TS_COUNT_RESET 8'h0f
`define TS_KEY_VALUE 8'h5c
`define TS_TICK_ZERO 16'h0000
`define TS_TICK_ONE 16'h0001
`define TS_SUP_ONE 8'h01
`define TS_DIV_ZERO 5'h00
`define TS_DIV_ONE 5'h01

`endif

// >>> common/tick_supervisor_pkg.sv
/*
  Holds the types shared by the tick timer and supervisor unit and its prescaler.
  Assumes the constants header is compiled alongside.
*/
`include "tick_supervisor_consts.svh"

package tick_supervisor_pkg;

  // --------------------------------------------------------------------------
  // Register port request
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // Supervisor run state
  typedef enum logic {SUP_OFF, SUP_RUN} sup_state_t;

  // Terminal value of the prescale count for a divide exponent; reserved codes clamp
  function automatic logic [4:0] div_limit(input logic [2:0] exp_code);
    logic [2:0] e;
    e = (exp_code > `TS_DIV_MAX) ? `TS_DIV_MAX : exp_code;
    div_limit = 5'((`TS_DIV_ONE << e) - `TS_DIV_ONE);
  endfunction

endpackage

// >>> verilog/slow_prescaler.sv
/*
  Detects rising edges of the slow input clock and divides them by a power of two.
  Assumes the slow clock is a level synchronous to core_clk and far slower than it.
*/
`timescale 1ns/100ps
`include "tick_supervisor_consts.svh"

module slow_prescaler (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Slow clock and divide exponent
  input wire logic slow_clk_in,
  input wire logic [2:0] divide_exponent,
  // One core cycle pulse per prescaled rising edge
  output logic presc_rise
);

  logic slow_prev_ff;
  logic [4:0] div_cnt_ff;
  logic slow_rise;

  // ----------------------------------------------------------------------------
  // Edge detect and divide
  // ----------------------------------------------------------------------------
  assign slow_rise = slow_clk_in & ~slow_prev_ff;

  // Previous level of the slow clock
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      slow_prev_ff <= 1'b0;
    end else begin
      slow_prev_ff <= slow_clk_in;
    end
  end

  // power of two
  // Counter wraps at the limit; a shrinking exponent may leave it high, which wraps once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_cnt_ff <= `TS_DIV_ZERO;
    end else if (slow_rise) begin
      if (div_cnt_ff >= tick_supervisor_pkg::div_limit(divide_exponent)) begin
        div_cnt_ff <= `TS_DIV_ZERO;
      end else begin
        div_cnt_ff <= 5'(div_cnt_ff + `TS_DIV_ONE);
      end
    end
  end

  assign presc_rise = slow_rise &&
    (div_cnt_ff >= tick_supervisor_pkg::div_limit(divide_exponent));

endmodule

// >>> verilog/tick_and_supervisor_unit.sv
/*
  Tick timer with auto reload and an 8-bit supervisory counter with key service,
  early/late detection and sticky lock bits, reached over a plain register port.
  Assumes the slow clock and the hardware clock-select lines are synchronous to core_clk
  and that software keeps preset and divide values in their legal ranges.
*/
// Design decisions made here: strobed register access and the register addresses.
// How it works
// - 16-bit tick counter counts down on prescaled edges, reloads after zero.
// - Tick output high for one prescaled cycle while counter is zero.
// - New preset only used at the next reload.
// - Restart bit reloads counter on next prescaled edge, which clears it.
// - Terminal count flag set at zero, cleared on read, read-only.
// - Prescaler divides slow clock by two to the divide exponent.
// - Tick preset resets to all ones; software uses 0001h to FFFFh.
// - Supervisor counter is 8-bit, idle and silent until started.
// - Write to count or key register starts it; only reset stops.
// - Count register resets to 0Fh; writes load and restart countdown.
// - Key 5Ch restarts from stored count; other key raises error.
// - Key writes ignored while key service is disabled.
// - Reaching zero without service raises error.
// - Two services within one supervisor clock raise error.
// - Clock select picks tick or prescaled clock; hardware override wins.
// - Lock bits set by software, cleared by reset, block writes and reads.
// - Tick lock blocks preset and control writes and preset reads.
// - Config holds locks, clock select, key enable; resets to zero.
// - Counters keep running in idle; registers used only when active.
// - Writes may lag up to 3 slow cycles; software avoids idle then.
// - Clock source switch may gain or lose one supervisor count.
// - At divide zero a load may skip one count.
`timescale 1ns/100ps
`include "tick_supervisor_consts.svh"

module tick_and_supervisor_unit (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Slow input clock and hardware clock-select override
  input wire logic slow_clk_in,
  input wire logic hw_sel_override,
  input wire logic hw_sel_prescaled,
  // Register port
  input wire tick_supervisor_pkg::reg_req_t bus_req,
  output logic [15:0] rdata,
  // Timing outputs
  output logic tick_output,
  output logic prescaled_clock,
  output logic supervisor_error
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  logic [7:0] config_ff;
  logic [2:0] div_ff;
  logic [15:0] preset_ff;
  logic [15:0] tick_count_ff;
  logic [15:0] nxt_tick_count;
  logic tick_out_ff;
  logic restart_ff;
  logic tc_ff;
  logic [7:0] reload_ff;
  logic [7:0] sup_count_ff;
  logic serviced_ff;
  logic error_ff;
  logic [15:0] rdata_ff;
  tick_supervisor_pkg::sup_state_t sup_state_ff;
  logic presc_rise;
  logic zero_evt;
  logic sup_edge;
  logic sup_sel;
  logic cfg_wr, pre_wr, preset_wr, csr_wr, count_wr, key_wr, key_ok;
  logic csr_rd, service, early_err, late_err, key_err;
  logic lock_cfg, lock_pre, lock_tick, lock_cnt, key_en;

  assign lock_cfg = config_ff[`TS_CFG_LOCK_CFG];
  assign lock_pre = config_ff[`TS_CFG_LOCK_PRE];
  assign lock_tick = config_ff[`TS_CFG_LOCK_TICK];
  assign lock_cnt = config_ff[`TS_CFG_LOCK_CNT];
  assign key_en = config_ff[`TS_CFG_KEY_EN];

  // ----------------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------------
  // immediate writes
  // Writes land at the next core edge, well inside the allowed slow-cycle lag
  // lock gating
  // Locked registers simply drop writes; no error is reported to software
  assign cfg_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_CONFIG) && !lock_cfg;
  assign pre_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_PRESCALER) && !lock_pre;
  assign preset_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_PRESET) && !lock_tick;
  assign csr_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_CSR) && !lock_tick;
  assign count_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_COUNT) && !lock_cnt;
  assign key_wr = bus_req.wr && (bus_req.addr == `TS_ADDR_KEY) && key_en;
  assign key_ok = key_wr && (bus_req.wdata[7:0] == `TS_KEY_VALUE);
  assign csr_rd = bus_req.rd && (bus_req.addr == `TS_ADDR_CSR);

  // ----------------------------------------------------------------------------
  // Configuration and prescaler registers
  // ----------------------------------------------------------------------------
  // config reset
  // Lock bits only ever accumulate, so a later write cannot unlock anything
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      config_ff <= `TS_CFG_RESET;
    end else if (cfg_wr) begin
      config_ff <= (bus_req.wdata[7:0] & `TS_CFG_MASK) | (config_ff & `TS_CFG_LOCK_MASK);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_ff <= `TS_DIV_RESET;
    end else if (pre_wr) begin
      div_ff <= bus_req.wdata[2:0];
    end
  end

  // always counting
  // Prescaler runs regardless of idle state; there is no gating input
  slow_prescaler slow_prescaler_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow_clk_in(slow_clk_in),
    .divide_exponent(div_ff),
    .presc_rise(presc_rise)
  );

  // ----------------------------------------------------------------------------
  // Tick timer
  // ----------------------------------------------------------------------------
  // preset reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preset_ff <= `TS_PRESET_RESET;
    end else if (preset_wr) begin
      preset_ff <= bus_req.wdata;
    end
  end

  always_comb begin
    if (restart_ff || (tick_count_ff == `TS_TICK_ZERO)) begin
      nxt_tick_count = preset_ff;
    end else begin
      nxt_tick_count = 16'(tick_count_ff - `TS_TICK_ONE);
    end
  end

  assign zero_evt = presc_rise && (nxt_tick_count == `TS_TICK_ZERO);

  // Counter and tick level advance together on the prescaled edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tick_count_ff <= `TS_PRESET_RESET;
      tick_out_ff <= 1'b0;
    end else if (presc_rise) begin
      tick_count_ff <= nxt_tick_count;
      tick_out_ff <= (nxt_tick_count == `TS_TICK_ZERO);
    end
  end

  // restart bit
  // A write landing on the clearing edge wins, so the request is never lost
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      restart_ff <= 1'b0;
    end else if (csr_wr && bus_req.wdata[`TS_CSR_RESTART]) begin
      restart_ff <= 1'b1;
    end else if (presc_rise) begin
      restart_ff <= 1'b0;
    end
  end

  // terminal count
  // Set beats the read clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tc_ff <= 1'b0;
    end else if (zero_evt) begin
      tc_ff <= 1'b1;
    end else if (csr_rd) begin
      tc_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Supervisor
  // ----------------------------------------------------------------------------
  // clock select
  // source switch
  // Switching mid-period just changes which edge is counted next, off by one at most
  assign sup_sel = hw_sel_override ? hw_sel_prescaled : config_ff[`TS_CFG_CLK_SEL];
  assign sup_edge = sup_sel ? presc_rise : zero_evt;

  assign service = count_wr || key_ok;
  assign early_err = service && serviced_ff;
  assign late_err = (sup_state_ff == tick_supervisor_pkg::SUP_RUN) && sup_edge &&
    !service && (sup_count_ff <= `TS_SUP_ONE);
  assign key_err = key_wr && !key_ok;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sup_state_ff <= tick_supervisor_pkg::SUP_OFF;
    end else if (count_wr || key_wr) begin
      sup_state_ff <= tick_supervisor_pkg::SUP_RUN;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reload_ff <= `TS_COUNT_RESET;
    end else if (count_wr) begin
      reload_ff <= bus_req.wdata[7:0];
    end
  end

  // load on edge
  // A load in the same cycle as an edge takes the load, so that edge is not counted
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sup_count_ff <= `TS_COUNT_RESET;
    end else if (count_wr) begin
      sup_count_ff <= bus_req.wdata[7:0];
    end else if (key_ok) begin
      sup_count_ff <= reload_ff;
    end else if ((sup_state_ff == tick_supervisor_pkg::SUP_RUN) && sup_edge) begin
      // After a late error the countdown restarts from the stored count
      sup_count_ff <= late_err ? reload_ff : 8'(sup_count_ff - `TS_SUP_ONE);
    end
  end

  // Marks a service seen since the last supervisor edge; service beats the edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      serviced_ff <= 1'b0;
    end else if (service) begin
      serviced_ff <= 1'b1;
    end else if (sup_edge) begin
      serviced_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      error_ff <= 1'b0;
    end else begin
      error_ff <= early_err || late_err || key_err;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  // locked reads
  // Locked and write-only registers read zero, a safe form of undefined data
  always_ff @(posedge core_clk) begin
    if (!rst_n || !bus_req.rd) begin
      rdata_ff <= 16'h0000;
    end else begin
      unique case (bus_req.addr)
        `TS_ADDR_CONFIG: rdata_ff <= lock_cfg ? 16'h0000 : {8'h00, config_ff};
        `TS_ADDR_PRESCALER: rdata_ff <= lock_pre ? 16'h0000 : {13'h0000, div_ff};
        `TS_ADDR_PRESET: rdata_ff <= lock_tick ? 16'h0000 : preset_ff;
        `TS_ADDR_CSR: rdata_ff <= {14'h0000, tc_ff, restart_ff};
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  assign rdata = rdata_ff;
  assign tick_output = tick_out_ff;
  assign prescaled_clock = presc_rise;
  assign supervisor_error = error_ff;

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  tick_reload_a:
    assert property (presc_rise && !restart_ff && tick_count_ff == `TS_TICK_ZERO
      |=> tick_count_ff == $past(preset_ff)) else $error("tick counter did not reload");
  tick_decrement_a:
    assert property (presc_rise && !restart_ff && tick_count_ff != `TS_TICK_ZERO
      |=> tick_count_ff == 16'($past(tick_count_ff) - 16'h0001))
      else $error("tick counter did not decrement");
  tick_level_a:
    assert property (tick_output |-> tick_count_ff == `TS_TICK_ZERO)
      else $error("tick output high with nonzero count");
  preset_deferred_a:
    assert property (preset_wr && !presc_rise ##1 !presc_rise
      |-> tick_count_ff == $past(tick_count_ff)) else $error("preset write disturbed count");
  restart_load_a:
    assert property (restart_ff && presc_rise && !csr_wr
      |=> !restart_ff && tick_count_ff == $past(preset_ff))
      else $error("restart did not reload and clear");
  tc_set_a:
    assert property (zero_evt |=> tc_ff) else $error("terminal count flag not set");
  tc_clear_a:
    assert property (csr_rd && !zero_evt |=> !tc_ff) else $error("terminal count not cleared");
  sup_silent_a:
    assert property (sup_state_ff == tick_supervisor_pkg::SUP_OFF && !key_wr
      |=> !supervisor_error) else $error("error raised before supervisor start");
  sup_start_a:
    assert property (count_wr |=> sup_state_ff == tick_supervisor_pkg::SUP_RUN [*3])
      else $error("supervisor did not start or stopped");
  sup_load_a:
    assert property (count_wr |=> sup_count_ff == $past(bus_req.wdata[7:0]))
      else $error("count write not loaded");
  bad_key_a:
    assert property (key_wr && !key_ok |=> supervisor_error) else $error("bad key not flagged");
  key_ignored_a:
    assert property (bus_req.wr && bus_req.addr == `TS_ADDR_KEY && !key_en && !serviced_ff &&
      sup_state_ff == tick_supervisor_pkg::SUP_OFF
      |=> sup_state_ff == tick_supervisor_pkg::SUP_OFF)
      else $error("disabled key write started supervisor");
  early_service_a:
    assert property (service && serviced_ff |=> supervisor_error)
      else $error("early service not flagged");
  late_error_a:
    assert property (late_err |=> supervisor_error && sup_count_ff == $past(reload_ff))
      else $error("late service not flagged or not reloaded");
  hw_select_a:
    assert property (hw_sel_override && !hw_sel_prescaled |-> sup_edge == zero_evt)
      else $error("hardware select did not force the tick clock");
  preset_locked_a:
    assert property (bus_req.wr && bus_req.addr == `TS_ADDR_PRESET && lock_tick
      |=> $stable(preset_ff)) else $error("locked preset changed");

  tick_seen_c: cover property (zero_evt ##[1:300] zero_evt);
  late_error_c: cover property (late_err ##1 supervisor_error);
  key_service_c: cover property (key_ok ##[1:300] sup_edge);

endmodule

// >>> tb/tick_and_supervisor_unit_tb_top.sv
/*
  Self-checking bench for the tick timer and supervisor unit.
  Assumes the slow clock may be modelled as a level synchronous to core_clk, eight core
  cycles a period, so that prescaled counts stay short.
*/
`timescale 1ns/100ps
`include "tick_supervisor_consts.svh"

module tick_and_supervisor_unit_tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow_clk_in = 1'b0;
  logic hw_sel_override = 1'b1;
  logic hw_sel_prescaled = 1'b1;
  tick_supervisor_pkg::reg_req_t bus_req = '0;
  logic [15:0] rdata;
  logic tick_output;
  logic prescaled_clock;
  logic supervisor_error;
  int err_total = 0;
  int cmp_count = 0;
  int err_seen = 0;
  int cycles = 0;
  int n;
  int a;
  logic rd_d = 1'b0;
  logic err_d = 1'b0;
  logic [31:0] seed = 32'h79ee;
  logic [31:0] e;
  logic [31:0] exp_q[$];
  logic [15:0] p;

  tick_and_supervisor_unit tick_and_supervisor_unit_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .slow_clk_in(slow_clk_in),
    .hw_sel_override(hw_sel_override),
    .hw_sel_prescaled(hw_sel_prescaled),
    .bus_req(bus_req),
    .rdata(rdata),
    .tick_output(tick_output),
    .prescaled_clock(prescaled_clock),
    .supervisor_error(supervisor_error)
  );

  // ----------------------------------------------------------------------
  // Clocks, timeout and output monitor
  // ----------------------------------------------------------------------
  always #4 core_clk = ~core_clk;

  // Scaled slow clock: real rate would cost thousands of core cycles per count
  always begin
    repeat (4) @(posedge core_clk);
    slow_clk_in <= ~slow_clk_in;
  end

  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      complete_run();
    end
  end

  // Sample at the falling edge, clear of the design's updates
  always @(negedge core_clk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      chk(e[15:0], rdata & e[31:16]);
    end
    if (supervisor_error) err_seen++;
    if (err_d) chk(16'h0, {15'h0, supervisor_error});
    rd_d = bus_req.rd;
    err_d = supervisor_error;
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [15:0] x, input logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, x, g);
    end
  endtask

  task automatic cyc(input int k);
    bus_req <= '0;
    repeat (k) @(posedge core_clk);
  endtask

  task automatic wr(input logic [2:0] ad, input logic [15:0] d);
    bus_req <= '{1'b1, 1'b0, ad, d};
    @(posedge core_clk);
  endtask

  // Expected value goes in the queue together with the bits that matter
  task automatic rd(input logic [2:0] ad, input logic [15:0] x, input logic [15:0] m);
    exp_q.push_back({m, x & m});
    bus_req <= '{1'b0, 1'b1, ad, 16'h0};
    @(posedge core_clk);
  endtask

  // Edges until the chosen output (inverted if asked) goes high
  task automatic rise(input bit s, output int k, input bit inv);
    logic pv;
    logic cv;
    bus_req <= '0;
    pv = 1'b1;
    for (k = 1; k < 3000; k++) begin
      @(posedge core_clk);
      #1;
      cv = (s ? prescaled_clock : tick_output) ^ inv;
      if (cv && !pv) break;
      pv = cv;
    end
  endtask

  task automatic errs(input int k, input int x);
    cyc(k);
    chk(16'(x), 16'(err_seen));
  endtask

  task automatic do_reset;
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    err_seen = 0;
  endtask

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    do_reset();
    rd(`TS_ADDR_CONFIG, `TS_CFG_RESET, 16'h00ff);
    rd(`TS_ADDR_PRESCALER, 16'h0, 16'h0007);
    rd(`TS_ADDR_PRESET, `TS_PRESET_RESET, 16'hffff);
    rd(`TS_ADDR_CSR, 16'h0, 16'h0003);
    rd(`TS_ADDR_COUNT, 16'h0, 16'hffff);
    rd(3'h6, 16'h0, 16'hffff);
    // Key write with key service off must neither start nor flag
    wr(`TS_ADDR_KEY, 16'h0011);
    errs(100, 0);
    for (int k = 0; k < 6; k++) begin
      wr(`TS_ADDR_PRESCALER, 16'(k));
      rd(`TS_ADDR_PRESCALER, 16'(k), 16'h0007);
      rise(1, n, 0);
      rise(1, n, 0);
      chk(16'(8 << k), 16'(n));
    end
    wr(`TS_ADDR_PRESCALER, 16'h0);
    // Tick period over the smallest preset and random ones
    for (int i = 0; i < 3; i++) begin
      seed = xs(seed);
      p = (i == 0) ? `TS_TICK_ONE : {13'h0, seed[2:0]} + 16'h1;
      wr(`TS_ADDR_PRESET, p);
      // Restart so the new preset is used without waiting out the old count
      wr(`TS_ADDR_CSR, 16'h1);
      rd(`TS_ADDR_PRESET, p, 16'hffff);
      rise(0, n, 0);
      rise(0, n, 0);
      chk(16'((p + 1) * 8), 16'(n));
      rise(0, n, 1);
      chk(16'h8, 16'(n));
      rd(`TS_ADDR_CSR, 16'h2, 16'h2);
      wr(`TS_ADDR_CSR, 16'h2);
      rd(`TS_ADDR_CSR, 16'h0, 16'h3);
    end
    // New preset written mid-count waits for the next reload
    wr(`TS_ADDR_PRESET, 16'h2);
    rise(0, n, 0);
    rise(0, n, 1);
    wr(`TS_ADDR_PRESET, 16'h5);
    rise(0, n, 0);
    chk(16'h10, 16'(n + 1));
    rise(0, n, 0);
    chk(16'h30, 16'(n));
    // Restart at count 3 stretches this period from 6 to 9 pulses
    rise(0, n, 0);
    rise(1, a, 0);
    rise(1, n, 0);
    a += n;
    rise(1, n, 0);
    a += n;
    wr(`TS_ADDR_CSR, 16'h1);
    rd(`TS_ADDR_CSR, 16'h1, 16'h1);
    rise(0, n, 0);
    chk(16'h48, 16'(a + n + 2));
    rd(`TS_ADDR_CSR, 16'h0, 16'h1);
    // Tick lock: preset and restart writes dropped, preset unreadable
    rise(0, n, 0);
    wr(`TS_ADDR_CONFIG, 16'h0004);
    wr(`TS_ADDR_PRESET, 16'h3);
    wr(`TS_ADDR_CSR, 16'h1);
    rise(0, n, 0);
    chk(16'h30, 16'(n + 3));
    rd(`TS_ADDR_PRESET, 16'h0, 16'hffff);
    rd(`TS_ADDR_CONFIG, 16'h4, 16'h00ff);
    wr(`TS_ADDR_CONFIG, 16'h0002);
    wr(`TS_ADDR_PRESCALER, 16'h5);
    rd(`TS_ADDR_PRESCALER, 16'h0, 16'hffff);
    rise(1, n, 0);
    rise(1, n, 0);
    chk(16'h8, 16'(n));
    wr(`TS_ADDR_CONFIG, 16'h0001);
    rd(`TS_ADDR_CONFIG, 16'h0, 16'hffff);
    // Late service, with the hardware select forcing the prescaled clock
    do_reset();
    wr(`TS_ADDR_COUNT, 16'h3);
    errs(12, 0);
    errs(16, 1);
    errs(48, 3);
    err_seen = 0;
    // Service every second edge keeps it quiet
    repeat (8) begin
      wr(`TS_ADDR_COUNT, 16'h3);
      cyc(15);
    end
    errs(1, 0);
    wr(`TS_ADDR_COUNT, 16'h3);
    wr(`TS_ADDR_COUNT, 16'h3);
    errs(3, 1);
    // Key service, config select chooses the prescaled clock
    do_reset();
    hw_sel_override <= 1'b0;
    wr(`TS_ADDR_CONFIG, 16'h0030);
    wr(`TS_ADDR_KEY, {8'h0, `TS_KEY_VALUE});
    errs(100, 0);
    errs(40, 1);
    wr(`TS_ADDR_KEY, {8'h0, `TS_KEY_VALUE});
    cyc(10);
    wr(`TS_ADDR_KEY, 16'h005d);
    errs(3, 2);
    wr(`TS_ADDR_CONFIG, 16'h0010);
    wr(`TS_ADDR_KEY, 16'h0011);
    errs(3, 2);
    // Hardware select forces the tick, so prescaled edges must not count down
    hw_sel_override <= 1'b1;
    hw_sel_prescaled <= 1'b0;
    wr(`TS_ADDR_COUNT, 16'h3);
    errs(40, 2);
    // Count lock: a count write neither loads nor starts
    do_reset();
    wr(`TS_ADDR_CONFIG, 16'h0018);
    wr(`TS_ADDR_COUNT, 16'h2);
    errs(60, 0);
    cyc(3);
    complete_run();
  end
endmodule
